// >>> shared/swc_defines.svh
// Timing counts and register map of the sleep and wake controller
`ifndef SWC_DEFINES_SVH
`define SWC_DEFINES_SVH

`define SWC_CLK_HZ        100000000
`define SWC_STAB_US       5000
`define SWC_STAB_CYC      ((`SWC_CLK_HZ / 1000000) * `SWC_STAB_US)
`define SWC_SEC_MS        1000
`define SWC_SEC_CYC       ((`SWC_CLK_HZ / 1000) * `SWC_SEC_MS)
`define SWC_PAGE_PER_MS   1000
`define SWC_PAGE_PER_CYC  ((`SWC_CLK_HZ / 1000) * `SWC_PAGE_PER_MS)
`define SWC_PAGE_WIN_MS   10
`define SWC_PAGE_WIN_CYC  ((`SWC_CLK_HZ / 1000) * `SWC_PAGE_WIN_MS)

`define SWC_OFF_CTRL      12'h000
`define SWC_OFF_STATUS    12'h004
`define SWC_OFF_IRQ_STAT  12'h008
`define SWC_OFF_IRQ_MASK  12'h00c
`define SWC_OFF_ALERT     12'h010

`define SWC_DELAY_RST     8'h00
`define SWC_ALERT_RST     3'h7
`define SWC_IRQ_W         3
`define SWC_IRQ_WAKE      0
`define SWC_IRQ_SLEEP     1
`define SWC_IRQ_NET       2
`define SWC_ALERT_PIN     0
`define SWC_ALERT_SER     1
`define SWC_ALERT_RING    2

`endif

// >>> shared/swc_pkg.sv
// Types of the sleep and wake controller
package swc_pkg;
	typedef enum logic [2:0] {
		SWC_IDLE,
		SWC_WAIT,
		SWC_SLEEP,
		SWC_PAGE,
		SWC_STAB
	} swc_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} swc_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} swc_apb_rsp_t;

	typedef struct packed {
		swc_state_t  st;
		logic [31:0] cnt;
		logic [31:0] sec_cnt;
		logic [7:0]  sec_left;
		logic [31:0] page_cnt;
		logic [7:0]  delay;
		logic        ser_block;
		logic [2:0]  alert_cfg;
		logic [2:0]  irq_stat;
		logic [2:0]  irq_mask;
		logic        net_pend;
		logic        wk_m;
		logic        wk_s;
		logic        wk_d;
		logic        us_m;
		logic        us_s;
		logic        sb_m;
		logic        sb_s;
		logic        sb_d;
		logic        nt_m;
		logic        nt_s;
		logic        nt_d;
		logic        ack_m;
		logic        ack_s;
		logic        cts_n;
		logic        alert_n;
		logic        ring_n;
		logic        ser_ev;
		logic        awake;
		logic        irq;
		swc_apb_rsp_t rsp;
	} swc_state_vec_t;
endpackage

// >>> design/swc_top.sv
// Sleep and wake controller with APB register access
`timescale 1ns/10ps
`include "swc_defines.svh"

// How it works
// R1 - Wait stabilisation interval after every wake
// R2 - Keep clear-to-send high while stabilising
// R3 - Low wake input moves sleep to idle
// R4 - Stay idle while wake input low
// R5 - Wake release: sleep after configured delay
// R6 - Host uses wake input when serial blocked
// R7 - Network indication wakes device, interfaces on
// R8 - Alert host by configured alert methods
// R9 - No sleep during transfer or unprocessed data
// R10 - After transfer processed, sleep after delay
// R11 - Delay zero forces idle immediately
// R12 - Stay awake until delay non-zero again
// R13 - Host disables sleep only when serial active; code accepts a zero delay write in any state
// R14 - No sleep while USB is active
// R15 - Delay in seconds; zero default disables
// R16 - Sleep pages periodically with clear-to-send low
// R17 - Serial block keeps clear-to-send high asleep
// R18 - Clear-to-send low means serial ready
// R19 - Delay count restarts when wake source ends
module swc_top #(
	parameter int unsigned STAB_CYC     = `SWC_STAB_CYC,
	parameter int unsigned SEC_CYC      = `SWC_SEC_CYC,
	parameter int unsigned PAGE_PER_CYC = `SWC_PAGE_PER_CYC,
	parameter int unsigned PAGE_WIN_CYC = `SWC_PAGE_WIN_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr,
	input  wire logic        host_wake_in_n,
	input  wire logic        usb_active,
	input  wire logic        serial_busy,
	input  wire logic        net_indication,
	input  wire logic        alert_done,
	output logic             serial_cts_n,
	output logic             host_alert_out_n,
	output logic             ring_indicator_n,
	output logic             serial_alert_req,
	output logic             awake,
	output logic             irq
);
	// Paging needs at least one sleeping cycle per period
	if (STAB_CYC < 1 || SEC_CYC < 1 || PAGE_WIN_CYC < 1 ||
	    PAGE_PER_CYC <= PAGE_WIN_CYC) begin
		$error("swc_top: timing parameters out of range");
	end

	swc_pkg::swc_state_vec_t s_r;
	swc_pkg::swc_state_vec_t s_nxt;
	swc_pkg::swc_apb_req_t   req;

	assign req = '{psel: psel, penable: penable, pwrite: pwrite,
		paddr: paddr, pwdata: pwdata};

	assign pready           = s_r.rsp.pready;
	assign prdata           = s_r.rsp.prdata;
	assign pslverr          = s_r.rsp.pslverr;
	assign serial_cts_n     = s_r.cts_n;
	assign host_alert_out_n = s_r.alert_n;
	assign ring_indicator_n = s_r.ring_n;
	assign serial_alert_req = s_r.ser_ev;
	assign awake            = s_r.awake;
	assign irq              = s_r.irq;

	logic       setup;
	logic       wr;
	logic       wake_hold;
	logic       src_end;
	logic [2:0] ev;

	always_comb begin
		s_nxt = s_r;
		setup = req.psel && !req.penable;
		wr = req.psel && req.penable && req.pwrite && s_r.rsp.pready;

		// Two-stage synchronisers for pins from other domains
		s_nxt.wk_m  = host_wake_in_n;
		s_nxt.wk_s  = s_r.wk_m;
		s_nxt.wk_d  = s_r.wk_s;
		s_nxt.us_m  = usb_active;
		s_nxt.us_s  = s_r.us_m;
		s_nxt.sb_m  = serial_busy;
		s_nxt.sb_s  = s_r.sb_m;
		s_nxt.sb_d  = s_r.sb_s;
		s_nxt.nt_m  = net_indication;
		s_nxt.nt_s  = s_r.nt_m;
		s_nxt.nt_d  = s_r.nt_s;
		s_nxt.ack_m = alert_done;
		s_nxt.ack_s = s_r.ack_m;

		ev = '0;
		// A new network event beats a handled one in the same cycle
		if (s_r.net_pend && s_r.ack_s)
			s_nxt.net_pend = 1'b0;
		if (s_r.nt_s && !s_r.nt_d)
			s_nxt.net_pend = 1'b1;

		// Anything that forbids sleep
		wake_hold = !s_r.wk_s || s_r.sb_s || s_r.net_pend ||
			s_r.us_s || (s_r.delay == 8'h00); // [R4] [R9] [R14] [R12]
		src_end = (s_r.wk_s && !s_r.wk_d) || (!s_r.sb_s && s_r.sb_d) ||
			(s_r.net_pend && s_r.ack_s); // [R19]

		s_nxt.ser_ev = 1'b0;

		case (s_r.st)
		swc_pkg::SWC_IDLE: begin
			s_nxt.cts_n = 1'b0; // [R18]
			if (!wake_hold) begin
				s_nxt.st       = swc_pkg::SWC_WAIT;
				s_nxt.sec_cnt  = '0;
				s_nxt.sec_left = s_r.delay; // [R15]
			end
		end
		swc_pkg::SWC_WAIT: begin
			s_nxt.cts_n = 1'b0;
			if (wake_hold) begin
				s_nxt.st = swc_pkg::SWC_IDLE; // [R11]
			end else if (src_end) begin
				s_nxt.sec_cnt  = '0;
				s_nxt.sec_left = s_r.delay; // [R19]
			end else if (s_r.sec_cnt == 32'(SEC_CYC - 1)) begin
				s_nxt.sec_cnt = '0;
				if (s_r.sec_left <= 8'h01) begin
					s_nxt.st       = swc_pkg::SWC_SLEEP; // [R5] [R10]
					s_nxt.awake    = 1'b0;
					s_nxt.page_cnt = '0;
					s_nxt.cts_n    = 1'b1;
					ev[`SWC_IRQ_SLEEP] = 1'b1;
				end else begin
					s_nxt.sec_left = s_r.sec_left - 8'h01;
				end
			end else begin
				s_nxt.sec_cnt = s_r.sec_cnt + 32'h1;
			end
		end
		swc_pkg::SWC_SLEEP, swc_pkg::SWC_PAGE: begin
			s_nxt.page_cnt = s_r.page_cnt + 32'h1;
			if (!s_r.wk_s || s_r.nt_s || s_r.net_pend || s_r.us_s ||
			    s_r.delay == 8'h00 ||
			    (s_r.st == swc_pkg::SWC_PAGE && s_r.sb_s)) begin
				// Wake: pin, network, USB, delay zero or paging data
				s_nxt.st    = swc_pkg::SWC_STAB; // [R3] [R7] [R11]
				s_nxt.cnt   = '0;
				s_nxt.cts_n = 1'b1;
			end else if (s_r.st == swc_pkg::SWC_SLEEP) begin
				s_nxt.cts_n = 1'b1;
				// Window spans counts PER-WIN up to PER-1
				if (s_r.page_cnt >=
				    32'(PAGE_PER_CYC - PAGE_WIN_CYC - 1)) begin
					s_nxt.st    = swc_pkg::SWC_PAGE;
					s_nxt.cts_n = s_r.ser_block; // [R16] [R17]
				end
			end else begin
				s_nxt.cts_n = s_r.ser_block; // [R17]
				if (s_r.page_cnt >= 32'(PAGE_PER_CYC - 1)) begin
					s_nxt.st       = swc_pkg::SWC_SLEEP; // [R16]
					s_nxt.page_cnt = '0;
					s_nxt.cts_n    = 1'b1;
				end
			end
		end
		swc_pkg::SWC_STAB: begin
			s_nxt.awake = 1'b1; // [R7]
			s_nxt.cts_n = 1'b1; // [R2]
			if (s_r.cnt == 32'(STAB_CYC - 1)) begin
				s_nxt.st    = swc_pkg::SWC_IDLE; // [R1]
				s_nxt.cts_n = 1'b0; // [R2] [R18]
				ev[`SWC_IRQ_WAKE] = 1'b1;
				if (s_r.net_pend) begin
					ev[`SWC_IRQ_NET] = 1'b1;
					// Alert methods chosen by software
					if (s_r.alert_cfg[`SWC_ALERT_PIN])
						s_nxt.alert_n = 1'b0; // [R8]
					if (s_r.alert_cfg[`SWC_ALERT_RING])
						s_nxt.ring_n = 1'b0; // [R8]
					s_nxt.ser_ev = s_r.alert_cfg[`SWC_ALERT_SER]; // [R8]
				end
			end else begin
				s_nxt.cnt = s_r.cnt + 32'h1;
			end
		end
		default: s_nxt.st = swc_pkg::SWC_IDLE;
		endcase

		// Alert lines released once the host has handled the event
		if (!s_r.net_pend) begin
			s_nxt.alert_n = 1'b1;
			s_nxt.ring_n  = 1'b1;
		end

		// APB slave: no wait state, answer in the first access cycle
		s_nxt.rsp.pready  = setup;
		s_nxt.rsp.pslverr = 1'b0;
		if (setup) begin
			s_nxt.rsp.prdata = '0;
			case (req.paddr)
			`SWC_OFF_CTRL: s_nxt.rsp.prdata =
				{23'h0, s_r.ser_block, s_r.delay};
			`SWC_OFF_STATUS: s_nxt.rsp.prdata =
				{28'h0, s_r.awake, s_r.st};
			`SWC_OFF_IRQ_STAT: s_nxt.rsp.prdata = {29'h0, s_r.irq_stat};
			`SWC_OFF_IRQ_MASK: s_nxt.rsp.prdata = {29'h0, s_r.irq_mask};
			`SWC_OFF_ALERT: s_nxt.rsp.prdata = {29'h0, s_r.alert_cfg};
			default: s_nxt.rsp.pslverr = 1'b1;
			endcase
		end
		if (req.psel && req.penable && !s_r.rsp.pready)
			s_nxt.rsp.pslverr = 1'b0;
		if (wr) begin
			case (req.paddr)
			`SWC_OFF_CTRL: begin
				s_nxt.delay     = req.pwdata[7:0]; // [R11] [R15]
				s_nxt.ser_block = req.pwdata[8];
			end
			`SWC_OFF_IRQ_STAT:
				s_nxt.irq_stat = s_r.irq_stat & ~req.pwdata[2:0];
			`SWC_OFF_IRQ_MASK: s_nxt.irq_mask = req.pwdata[2:0];
			`SWC_OFF_ALERT: s_nxt.alert_cfg = req.pwdata[2:0];
			default: s_nxt.irq_stat = s_nxt.irq_stat;
			endcase
		end
		// Set beats clear in the same cycle
		s_nxt.irq_stat = s_nxt.irq_stat | ev;
		s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r           <= '0;
			s_r.st        <= swc_pkg::SWC_IDLE;
			s_r.delay     <= `SWC_DELAY_RST; // [R15]
			s_r.alert_cfg <= `SWC_ALERT_RST;
			s_r.wk_m      <= 1'b1;
			s_r.wk_s      <= 1'b1;
			s_r.wk_d      <= 1'b1;
			s_r.cts_n     <= 1'b0;
			s_r.alert_n   <= 1'b1;
			s_r.ring_n    <= 1'b1;
			s_r.awake     <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule

// >>> sim/swc_host_model.sv
// Host side model driving the wake pin and the serial busy line
`timescale 1ns/10ps
module swc_host_model (
	input  wire logic pclk,
	input  wire logic wake_req,
	input  wire logic xfer_req,
	input  wire logic blocked,
	output logic      host_wake_in_n = 1'b1,
	output logic      serial_busy = 1'b0
);
	always_ff @(posedge pclk) begin
		// Blocked serial: wake pin pulled low on the same edge as the busy line
		host_wake_in_n <= !(wake_req || (xfer_req && blocked));
		serial_busy <= xfer_req;
	end
endmodule

// >>> sim/swc_checker.sv
// Assertions on the ports of the sleep and wake controller
`timescale 1ns/10ps
module swc_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        host_wake_in_n,
	input wire logic        usb_active,
	input wire logic        serial_busy,
	input wire logic        serial_cts_n,
	input wire logic        host_alert_out_n,
	input wire logic        awake
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence page_open_s; !awake && $fell(serial_cts_n); endsequence
	sequence page_win_s; !serial_cts_n[*8]; endsequence
	sequence zero_wr_s;
		psel && penable && pready && pwrite && paddr == 12'h000 &&
			pwdata[7:0] == 8'h00;
	endsequence
	stab_cts_a: assert property (
		$rose(awake) |-> serial_cts_n[*8]) else $error("cts early");
	pin_wake_a: assert property (
		!awake && !host_wake_in_n |-> ##[1:5] awake) else $error("no wake");
	pin_hold_a: assert property (
		$fell(awake) |-> $past(host_wake_in_n, 5)) else $error("slept");
	busy_hold_a: assert property (
		$fell(awake) |-> !$past(serial_busy, 5)) else $error("slept busy");
	usb_hold_a: assert property (
		$fell(awake) |-> !$past(usb_active, 5)) else $error("slept usb");
	page_win_a: assert property (
		page_open_s |-> page_win_s ##[1:6] serial_cts_n) else $error("page");
	alert_up_a: assert property (
		$fell(host_alert_out_n) |-> ##[0:2] awake && !serial_cts_n)
		else $error("alert asleep");
	zero_wake_a: assert property (
		zero_wr_s |-> ##[1:3] awake[*8]) else $error("zero delay");
	apb_ready_a: assert property (
		psel && !penable |=> pready) else $error("pready late");
endmodule
bind swc_top swc_checker chk_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.host_wake_in_n(host_wake_in_n), .usb_active(usb_active),
	.serial_busy(serial_busy), .serial_cts_n(serial_cts_n),
	.host_alert_out_n(host_alert_out_n), .awake(awake));

// >>> sim/tb.sv
// Testbench for the sleep and wake controller
`timescale 1ns/10ps
module tb;
	logic        pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic        pready, pslverr, er, wk_n, busy, cts_n, alrt_n, ring_n;
	logic        awake, irq, usb = 0, net = 0, done = 0, ser_req;
	logic        wreq = 0, xreq = 0, blk = 0;
	int          errors = 0, tests_run = 0, n, k, d, alerts = 0;
	swc_host_model hm (.pclk(pclk), .wake_req(wreq), .xfer_req(xreq),
		.blocked(blk), .host_wake_in_n(wk_n), .serial_busy(busy));
	swc_top #(.STAB_CYC(20), .SEC_CYC(50), .PAGE_PER_CYC(200),
		.PAGE_WIN_CYC(10)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .host_wake_in_n(wk_n), .usb_active(usb),
		.serial_busy(busy), .net_indication(net), .alert_done(done),
		.serial_cts_n(cts_n), .host_alert_out_n(alrt_n),
		.ring_indicator_n(ring_n), .serial_alert_req(ser_req),
		.awake(awake), .irq(irq));
	initial begin
		forever #5 pclk = ~pclk;
	end
	// Serial alert requests are single-cycle pulses
	always @(posedge pclk) begin
		if (ser_req === 1'b1) alerts <= alerts + 1;
	end
	function automatic logic in_sleep_span(int c, int d);
		return c >= d * 50 && c <= d * 50 + 10;
	endfunction
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wt(logic v);
		n = 0;
		while (awake !== v && n < 3000) begin
			@(posedge pclk);
			n++;
		end
	endtask
	task automatic lowc();
		k = 0;
		repeat (200) begin
			@(posedge pclk);
			if (cts_n === 1'b0) k++;
		end
	endtask
	task automatic wrap_up();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#100000;
		errors++;
		wrap_up();
	end
	initial begin
		// Reset edge by a nonblocking write at time zero so the flops see it
		presetn <= 0;
		void'($urandom(32'h338c));
		repeat (3) @(posedge pclk);
		presetn <= 1;
		apb(0, 12'h000, 0); chk("ctrl", 0, rd);
		apb(0, 12'h010, 0); chk("alert_cfg", 7, rd);
		apb(0, 12'h020, 0); chk("unmapped", 1, er);
		apb(1, 12'h00c, 7);
		apb(1, 12'h000, 1); wt(0); chk("sleep", 1, in_sleep_span(n, 1));
		chk("irq", 1, irq);
		apb(1, 12'h008, 7); repeat (2) @(posedge pclk);
		chk("irq_clr", 0, irq);
		wreq <= 1; wt(1); chk("pin_wake", 1, n <= 6);
		n = 0;
		while (cts_n !== 1'b0 && n < 100) begin @(posedge pclk); n++; end
		chk("stab", 1, n >= 19 && n <= 21);
		repeat (150) @(posedge pclk); chk("pin_hold", 1, awake);
		wreq <= 0; wt(0); chk("pin_rel", 1, in_sleep_span(n, 1));
		lowc(); chk("page", 10, k);
		apb(1, 12'h000, 32'h101); blk <= 1;
		lowc(); chk("block", 0, k);
		repeat (3) begin
			d = $urandom_range(1, 3);
			apb(1, 12'h000, 32'h100 | d);
			xreq <= 1; wt(1); chk("xfer_wake", 1, awake);
			// Pin released: only the busy line holds off sleep
			blk <= 0; repeat ($urandom_range(200, 300)) @(posedge pclk);
			chk("busy", 1, awake);
			xreq <= 0; wt(0); chk("xfer", 1, in_sleep_span(n, d));
			blk <= 1;
		end
		net <= 1; repeat (3) @(posedge pclk); net <= 0; wt(1);
		n = 0;
		while (alrt_n !== 1'b0 && n < 60) begin @(posedge pclk); n++; end
		chk("alert", 0, alrt_n); chk("ring", 0, ring_n);
		done <= 1; repeat (6) @(posedge pclk); chk("alert_off", 1, alrt_n);
		chk("ser_alert", 1, alerts);
		chk("irq_on", 1, irq);
		apb(0, 12'h008, 0); chk("irq_net", 7, rd);
		done <= 0; wt(0);
		usb <= 1; wt(1); repeat (300) @(posedge pclk);
		chk("usb", 1, awake);
		usb <= 0; wt(0);
		apb(1, 12'h000, 0); wt(1); chk("zero", 1, n <= 4);
		repeat (400) @(posedge pclk); chk("stay", 1, awake);
		apb(0, 12'h004, 0); chk("status", 32'h8, rd);
		wrap_up();
	end
endmodule
